/* pkg/mode_reg_pkg.sv */
// Purpose: Shared constants and carrier types for the mode register bank.
// Assumes: Eight-bit register data, eight-bit register address.
// Notes:   Field positions and codes are defined once here.
package mode_reg_pkg;

   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [7:0] DEVICE_INFORMATION_ADDR = 8'h00;
   localparam logic [7:0] DEVICE_FEATURE_ONE_ADDR = 8'h01;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int AUTO_INIT_STATUS_BIT     = 0;
   localparam int DEVICE_CLASS_INFO_BIT    = 1;
   localparam int DATA_INVALID_SUPPORT_BIT = 2;
   localparam int SELFTEST_LSB             = 3;
   localparam int BURST_LENGTH_LSB         = 0;
   localparam int BURST_ORDER_TYPE_BIT     = 3;
   localparam int WRAP_CONTROL_BIT         = 4;
   localparam int WRITE_RECOVERY_LSB       = 5;

   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic       DEVICE_CLASS_PREFETCH_FOUR = 1'h0;
   localparam logic       DATA_INVALID_NONE          = 1'h0;
   localparam logic [2:0] BURST_LEN_FOUR             = 3'h2;
   localparam logic [2:0] BURST_LEN_EIGHT            = 3'h3;
   localparam logic [2:0] BURST_LEN_SIXTEEN          = 3'h4;
   localparam logic       BURST_TYPE_SEQ             = 1'h0;
   localparam logic       BURST_TYPE_INT             = 1'h1;
   localparam logic       WRAP_ON                    = 1'h0;
   localparam logic       WRAP_OFF                   = 1'h1;
   localparam logic [2:0] WR_CODE_MIN                = 3'h1;
   localparam logic [2:0] WR_CODE_MAX                = 3'h6;
   localparam logic [3:0] WR_CYCLES_OFFSET           = 4'h2;
   localparam logic [2:0] WR_CODE_RESET              = 3'h1;
   localparam logic [1:0] SELFTEST_NOT_RUN           = 2'h0;
   localparam logic [1:0] SELFTEST_TIED_HIGH         = 2'h1;
   localparam logic [1:0] SELFTEST_SHORT_GND         = 2'h2;
   localparam logic [1:0] SELFTEST_OK                = 2'h3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_IDLE = 2'b00,
      CMD_READ = 2'b01,
      CMD_WRITE = 2'b10
   } mr_cmd_t;

   typedef struct packed {
      mr_cmd_t    cmd;
      logic [7:0] addr;
      logic [7:0] data;
   } mr_req_t;

   typedef struct packed {
      logic [2:0] write_recovery_cycles;
      logic       wrap_control;
      logic       burst_order_type;
      logic [2:0] burst_length_field;
   } feature_one_t;

endpackage : mode_reg_pkg

/* rtl/mode_reg_burst_order.sv */
// Purpose: Device information and feature-one mode registers, with the
//          column ordering and write recovery that the feature register selects.
// Assumes: Command decode upstream presents one mode register command per
//          cycle; burst requests come from the device core on the same clock.
// Notes:   Self-test and init inputs are pins and are synchronised here.
// What this block does
// - Info bit 0 reads 1 while auto-init runs, 0 once done.
// - Info bit 1 reads 0 (prefetch-four class), bit 2 reads 0 (no data-invalid).
// - Info bits 4:3 give self-test result: not run, tied high, shorted, ok.
// - Self-test field updates only when init calibration command finishes.
// - Calibration pin tied to supply deliberately reads back as 01.
// - Result 01 or 10 selects factory trim and ignores calibration commands.
// - Feature bits 2:0 choose burst length 4, 8 or 16; others reserved.
// - Feature bit 3 chooses sequential (default) or interleaved order.
// - Feature bit 4 chooses wrap or no-wrap; no-wrap only with four beats.
// - Feature bits 7:5 codes 1..6 give 3..8 recovery cycles; default 3.
// - Write with auto-precharge starts precharge after the recovery count.
// - Four-beat wrap uses column bits 1:0; start 2 gives 2,3,0,1.
// - Eight-beat wrap: sequential adds beat modulo 8, interleaved XORs.
// - Sixteen beats order sequentially modulo 16; no interleave, no no-wrap.
// - Column bit 0 is not carried and is always taken as zero.
// - Four-beat no-wrap walks y..y+3 linearly from even column y.
// - Writes to the information register change nothing.
// - Reserved information bits read as zero.
// - Reading the feature register returns undefined data but still strobes.
`timescale 1ns/100ps
`default_nettype none

module mode_reg_burst_order #(
   parameter int COL_W = 10
) (
   // Clock and reset
   input  wire logic                  SYS_CLK_IN,
   input  wire logic                  RESET_IN,
   // Mode register command port
   input  wire mode_reg_pkg::mr_req_t MR_REQ_IN,
   output var  logic [7:0]            MR_RDATA_OUT,
   output var  logic                  MR_RVALID_OUT,
   output logic                       MR_STROBE_OUT,
   // Pin-level status inputs
   input  wire logic                  AUTO_INIT_BUSY_IN,
   input  wire logic                  CALIB_DONE_IN,
   input  wire logic [1:0]            CALIB_RESULT_IN,
   // Calibration control
   input  wire logic                  CALIB_CMD_IN,
   output logic                       CALIB_CMD_ACCEPT_OUT,
   output var  logic                  FACTORY_TRIM_OUT,
   // Burst address generation
   input  wire logic                  BURST_START_IN,
   input  wire logic [COL_W-1:0]      BURST_COL_IN,
   output var  logic [COL_W-1:0]      BURST_COL_OUT,
   output var  logic                  BURST_VALID_OUT,
   output var  logic                  BURST_ILLEGAL_OUT,
   // Write recovery with auto-precharge
   input  wire logic                  WRITE_AP_END_IN,
   output var  logic                  PRECHARGE_START_OUT,
   // Current feature settings
   output mode_reg_pkg::feature_one_t FEATURE_OUT
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {CALIB_RESULT_IN, CALIB_DONE_IN, AUTO_INIT_BUSY_IN};
         sync2_r <= sync1_r;
      end
   end

   logic       init_busy;
   logic       calib_done;
   logic [1:0] calib_result;
   logic       calib_done_d_r;
   assign init_busy    = sync2_r[0];
   assign calib_done   = sync2_r[1];
   assign calib_result = sync2_r[3:2];

   // ------------------------------------------------------------
   // Self-test result
   // ------------------------------------------------------------
   logic [1:0] selftest_r;

   // The result is captured on the rising edge of the done level only, so a
   // result pin that wanders between calibrations cannot disturb the field.
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         calib_done_d_r <= 1'b0;
         selftest_r     <= mode_reg_pkg::SELFTEST_NOT_RUN;
      end else begin
         calib_done_d_r <= calib_done;
         if (calib_done && !calib_done_d_r) begin
            selftest_r <= calib_result;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         FACTORY_TRIM_OUT <= 1'b0;
      end else begin
         FACTORY_TRIM_OUT <= (selftest_r == mode_reg_pkg::SELFTEST_TIED_HIGH) ||
                             (selftest_r == mode_reg_pkg::SELFTEST_SHORT_GND);
      end
   end

   assign CALIB_CMD_ACCEPT_OUT = CALIB_CMD_IN && !FACTORY_TRIM_OUT;

   // ------------------------------------------------------------
   // Feature register
   // ------------------------------------------------------------
   mode_reg_pkg::feature_one_t feature_r;
   logic                       wr_feature;
   assign wr_feature = (MR_REQ_IN.cmd == mode_reg_pkg::CMD_WRITE) &&
                       (MR_REQ_IN.addr == mode_reg_pkg::DEVICE_FEATURE_ONE_ADDR);

   // Writes to any other address, the information register included, fall
   // through without effect.
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         feature_r.burst_length_field    <= mode_reg_pkg::BURST_LEN_FOUR;
         feature_r.burst_order_type      <= mode_reg_pkg::BURST_TYPE_SEQ;
         feature_r.wrap_control          <= mode_reg_pkg::WRAP_ON;
         feature_r.write_recovery_cycles <= mode_reg_pkg::WR_CODE_RESET;
      end else if (wr_feature) begin
         feature_r.burst_length_field <=
            MR_REQ_IN.data[mode_reg_pkg::BURST_LENGTH_LSB +: 3];
         feature_r.burst_order_type <=
            MR_REQ_IN.data[mode_reg_pkg::BURST_ORDER_TYPE_BIT];
         feature_r.wrap_control <=
            MR_REQ_IN.data[mode_reg_pkg::WRAP_CONTROL_BIT];
         feature_r.write_recovery_cycles <=
            MR_REQ_IN.data[mode_reg_pkg::WRITE_RECOVERY_LSB +: 3];
      end
   end

   assign FEATURE_OUT = feature_r;

   // ------------------------------------------------------------
   // Mode register read
   // ------------------------------------------------------------
   logic [7:0] info_value;
   always_comb begin
      info_value = 8'h00;
      info_value[mode_reg_pkg::AUTO_INIT_STATUS_BIT]     = init_busy;
      info_value[mode_reg_pkg::DEVICE_CLASS_INFO_BIT]    =
         mode_reg_pkg::DEVICE_CLASS_PREFETCH_FOUR;
      info_value[mode_reg_pkg::DATA_INVALID_SUPPORT_BIT] = mode_reg_pkg::DATA_INVALID_NONE;
      info_value[mode_reg_pkg::SELFTEST_LSB +: 2]        = selftest_r;
   end

   // Every read answers one cycle later with a strobe; registers other than
   // the information register return zero, which stands for undefined data.
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         MR_RDATA_OUT  <= 8'h00;
         MR_RVALID_OUT <= 1'b0;
      end else begin
         MR_RVALID_OUT <= (MR_REQ_IN.cmd == mode_reg_pkg::CMD_READ);
         if (MR_REQ_IN.cmd == mode_reg_pkg::CMD_READ) begin
            if (MR_REQ_IN.addr == mode_reg_pkg::DEVICE_INFORMATION_ADDR) begin
               MR_RDATA_OUT <= info_value;
            end else begin
               MR_RDATA_OUT <= 8'h00;
            end
         end
      end
   end

   assign MR_STROBE_OUT = MR_RVALID_OUT;

   // ------------------------------------------------------------
   // Burst address sequencer
   // ------------------------------------------------------------
   logic [3:0]       beat_r;
   logic [3:0]       last_beat_r;
   logic [COL_W-1:0] start_r;
   logic [3:0]       mask_r;
   logic             seq_r;
   logic             nowrap_r;
   logic [3:0]       beat_max;
   logic [3:0]       beat_mask;
   logic             combo_bad;

   always_comb begin
      beat_max  = 4'h3;
      beat_mask = 4'h3;
      combo_bad = 1'b0;
      if (feature_r.burst_length_field == mode_reg_pkg::BURST_LEN_EIGHT) begin
         beat_max  = 4'h7;
         beat_mask = 4'h7;
         combo_bad = feature_r.wrap_control;
      end else if (feature_r.burst_length_field == mode_reg_pkg::BURST_LEN_SIXTEEN) begin
         beat_max  = 4'hF;
         beat_mask = 4'hF;
         combo_bad = feature_r.wrap_control ||
                     (feature_r.burst_order_type == mode_reg_pkg::BURST_TYPE_INT);
      end else if (feature_r.burst_length_field != mode_reg_pkg::BURST_LEN_FOUR) begin
         combo_bad = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         BURST_VALID_OUT   <= 1'b0;
         BURST_ILLEGAL_OUT <= 1'b0;
         beat_r            <= 4'h0;
         last_beat_r       <= 4'h0;
         start_r           <= '0;
         mask_r            <= 4'h0;
         seq_r             <= 1'b1;
         nowrap_r          <= 1'b0;
      end else if (BURST_START_IN) begin
         BURST_ILLEGAL_OUT <= combo_bad;
         BURST_VALID_OUT   <= !combo_bad;
         beat_r            <= 4'h0;
         last_beat_r       <= beat_max;
         start_r           <= {BURST_COL_IN[COL_W-1:1], 1'b0};
         mask_r            <= beat_mask;
         seq_r             <= (feature_r.burst_order_type == mode_reg_pkg::BURST_TYPE_SEQ) ||
                              (feature_r.burst_length_field == mode_reg_pkg::BURST_LEN_FOUR);
         nowrap_r          <= feature_r.wrap_control;
      end else begin
         BURST_ILLEGAL_OUT <= 1'b0;
         if (BURST_VALID_OUT) begin
            if (beat_r == last_beat_r) begin
               BURST_VALID_OUT <= 1'b0;
            end else begin
               beat_r <= beat_r + 4'h1;
            end
         end
      end
   end

   // Four-beat wrap with an even start gives the same order for both types,
   // so it is steered down the sequential path.
   logic [3:0]       low_bits;
   logic [COL_W-1:0] col_next;
   always_comb begin
      if (seq_r) begin
         low_bits = (start_r[3:0] + beat_r) & mask_r;
      end else begin
         low_bits = (start_r[3:0] ^ beat_r) & mask_r;
      end
      if (nowrap_r) begin
         col_next = start_r + COL_W'(beat_r);
      end else begin
         col_next = (start_r & ~COL_W'(mask_r)) | COL_W'(low_bits);
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         BURST_COL_OUT <= '0;
      end else begin
         BURST_COL_OUT <= col_next;
      end
   end

   // ------------------------------------------------------------
   // Write recovery before auto-precharge
   // ------------------------------------------------------------
   logic [3:0] wr_count_r;
   logic       wr_run_r;
   logic [3:0] wr_cycles;
   assign wr_cycles = {1'b0, feature_r.write_recovery_cycles} + mode_reg_pkg::WR_CYCLES_OFFSET;

   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         wr_count_r          <= 4'h0;
         wr_run_r            <= 1'b0;
         PRECHARGE_START_OUT <= 1'b0;
      end else begin
         PRECHARGE_START_OUT <= 1'b0;
         if (WRITE_AP_END_IN) begin
            wr_count_r <= wr_cycles - 4'h1;
            wr_run_r   <= 1'b1;
         end else if (wr_run_r) begin
            if (wr_count_r == 4'h1) begin
               wr_run_r            <= 1'b0;
               PRECHARGE_START_OUT <= 1'b1;
            end
            wr_count_r <= wr_count_r - 4'h1;
         end
      end
   end

endmodule : mode_reg_burst_order

`default_nettype wire

/* sim/mode_reg_chk.sv */
// Purpose: Port-level assertions for the mode register bank.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Attached by the bind statement at the foot of this file.
`timescale 1ns/100ps
`default_nettype none

module mode_reg_chk #(
   parameter int COL_W = 10
) (
   input wire logic                       SYS_CLK_IN, RESET_IN, AUTO_INIT_BUSY_IN, CALIB_CMD_IN,
   input wire logic                       MR_RVALID_OUT, MR_STROBE_OUT, CALIB_CMD_ACCEPT_OUT,
   input wire logic                       FACTORY_TRIM_OUT, BURST_START_IN, BURST_VALID_OUT,
   input wire logic                       BURST_ILLEGAL_OUT, WRITE_AP_END_IN, PRECHARGE_START_OUT,
   input wire logic [7:0]                 MR_RDATA_OUT,
   input wire logic [COL_W-1:0]           BURST_COL_OUT,
   input wire mode_reg_pkg::mr_req_t      MR_REQ_IN,
   input wire mode_reg_pkg::feature_one_t FEATURE_OUT
);
   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (RESET_IN);

   sequence s_rd;
      MR_REQ_IN.cmd == mode_reg_pkg::CMD_READ;
   endsequence
   sequence s_rd_info;
      s_rd ##0 MR_REQ_IN.addr == mode_reg_pkg::DEVICE_INFORMATION_ADDR;
   endsequence
   // The busy pin passes two sync stages, so it must be steady that long.
   sequence s_busy_steady;
      $stable(AUTO_INIT_BUSY_IN) && AUTO_INIT_BUSY_IN == $past(AUTO_INIT_BUSY_IN, 2)
         && !$past(RESET_IN) && !$past(RESET_IN, 2);
   endsequence
   sequence s_wr;
      MR_REQ_IN.cmd == mode_reg_pkg::CMD_WRITE;
   endsequence

   a_read_strobe: assert property (s_rd |=> MR_RVALID_OUT && MR_STROBE_OUT)
      else $error("read gave no strobe");
   a_info_zero_bits: assert property (s_rd_info |=>
      MR_RDATA_OUT[7:5] == 3'h0 && MR_RDATA_OUT[2:1] == 2'h0)
      else $error("fixed info bits wrong");
   a_init_status: assert property (s_rd_info ##0 s_busy_steady |=>
      MR_RDATA_OUT[0] == $past(AUTO_INIT_BUSY_IN))
      else $error("init status wrong");
   a_feature_load: assert property (s_wr ##0
      MR_REQ_IN.addr == mode_reg_pkg::DEVICE_FEATURE_ONE_ADDR
      |=> FEATURE_OUT == $past(MR_REQ_IN.data))
      else $error("feature write lost");
   a_ro_write_none: assert property (s_wr ##0
      MR_REQ_IN.addr != mode_reg_pkg::DEVICE_FEATURE_ONE_ADDR |=> $stable(FEATURE_OUT))
      else $error("feature changed by other write");
   a_trim_blocks_cal: assert property (CALIB_CMD_IN |->
      CALIB_CMD_ACCEPT_OUT == !FACTORY_TRIM_OUT)
      else $error("calibration accept wrong");
   // The trim level follows the self-test field that a read reports.
   a_trim_from_field: assert property (s_rd_info |=>
      FACTORY_TRIM_OUT == (MR_RDATA_OUT[4:3] == mode_reg_pkg::SELFTEST_TIED_HIGH ||
                           MR_RDATA_OUT[4:3] == mode_reg_pkg::SELFTEST_SHORT_GND))
      else $error("factory trim disagrees with self-test field");
   a_recovery_min: assert property (WRITE_AP_END_IN &&
      FEATURE_OUT.write_recovery_cycles == mode_reg_pkg::WR_CODE_MIN
      |=> !PRECHARGE_START_OUT [*2] ##1 PRECHARGE_START_OUT)
      else $error("precharge not after 3 cycles");
   a_recovery_max: assert property (WRITE_AP_END_IN &&
      FEATURE_OUT.write_recovery_cycles == mode_reg_pkg::WR_CODE_MAX
      |=> !PRECHARGE_START_OUT [*7] ##1 PRECHARGE_START_OUT)
      else $error("precharge not after 8 cycles");
   a_nowrap_refused: assert property (BURST_START_IN && FEATURE_OUT.wrap_control
      && FEATURE_OUT.burst_length_field != mode_reg_pkg::BURST_LEN_FOUR
      |=> BURST_ILLEGAL_OUT && !BURST_VALID_OUT)
      else $error("no-wrap long burst accepted");
   // Later beats alternate odd and even; the first column of a burst is always even.
   a_col_even: assert property (BURST_START_IN |=> ##1 !BURST_COL_OUT[0])
      else $error("odd start column issued");
   a_four_beats: assert property (BURST_START_IN
      && FEATURE_OUT.burst_length_field == mode_reg_pkg::BURST_LEN_FOUR
      |=> BURST_VALID_OUT [*4] ##1 !BURST_VALID_OUT)
      else $error("four-beat burst length wrong");
endmodule : mode_reg_chk

bind mode_reg_burst_order mode_reg_chk #(.COL_W(COL_W)) u_mode_reg_chk (
   .SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN), .AUTO_INIT_BUSY_IN(AUTO_INIT_BUSY_IN),
   .CALIB_CMD_IN(CALIB_CMD_IN), .MR_RVALID_OUT(MR_RVALID_OUT), .MR_STROBE_OUT(MR_STROBE_OUT),
   .CALIB_CMD_ACCEPT_OUT(CALIB_CMD_ACCEPT_OUT), .FACTORY_TRIM_OUT(FACTORY_TRIM_OUT),
   .BURST_START_IN(BURST_START_IN), .BURST_VALID_OUT(BURST_VALID_OUT),
   .BURST_ILLEGAL_OUT(BURST_ILLEGAL_OUT), .WRITE_AP_END_IN(WRITE_AP_END_IN),
   .PRECHARGE_START_OUT(PRECHARGE_START_OUT), .MR_RDATA_OUT(MR_RDATA_OUT),
   .BURST_COL_OUT(BURST_COL_OUT), .MR_REQ_IN(MR_REQ_IN), .FEATURE_OUT(FEATURE_OUT)
);

`default_nettype wire

/* sim/mr_ctrl_model.sv */
// Purpose: Memory controller model issuing mode register commands.
// Assumes: One command per clock, driven just after the rising edge.
// Notes:   Recovery codes are derived from a time in ns and the clock period.
`timescale 1ns/100ps
`default_nettype none

module mr_ctrl_model #(
   parameter int TCK_NS = 50
) (
   input  wire logic                  clk_in,
   input  wire logic [7:0]            rdata_in,
   input  wire logic                  rvalid_in,
   input  wire logic                  strobe_in,
   output var  mode_reg_pkg::mr_req_t req_out
);
   initial req_out = '0;

   // The command stands for exactly the one edge that takes it. The answer is
   // launched on that edge, so it is taken at the next one, which keeps the
   // caller on the clock edge for whatever it drives next.
   task automatic mr_access(input mode_reg_pkg::mr_cmd_t cmd, input logic [7:0] addr,
                            input logic [7:0] data, output logic [8:0] resp);
      @(posedge clk_in);
      req_out <= '{cmd: cmd, addr: addr, data: data};
      @(posedge clk_in);
      req_out <= '0;
      @(posedge clk_in);
      resp = {rvalid_in & strobe_in, rdata_in};
   endtask : mr_access

   function automatic logic [7:0] feature_byte(input int twr_ns, input logic [4:0] low);
      int cyc;
      cyc = (twr_ns + TCK_NS - 1) / TCK_NS;
      return {3'(cyc - 2), low};
   endfunction : feature_byte
endmodule : mr_ctrl_model

`default_nettype wire

/* sim/mode_reg_burst_order_tb_top.sv */
// Purpose: Self-checking bench for the mode register bank.
// Assumes: 20 MHz clock, reset held six cycles.
// Notes:   Expected columns are rebuilt from the start column and settings.
`timescale 1ns/100ps
`default_nettype none

module mode_reg_burst_order_tb_top;
   localparam int COL_W = 10;
   logic clk = 1'b0, rst = 1'b1, busy = 1'b1, cdone = 1'b0, ccmd = 1'b0, bstart = 1'b0;
   logic apend = 1'b0, rvalid, strobe, accept, trim, bvalid, billegal, pre;
   logic [1:0] cres = 2'h0, prev = 2'h0;
   logic [7:0] rdata;
   logic [8:0] resp;
   logic [COL_W-1:0] bcol = '0, bcolo;
   mode_reg_pkg::mr_req_t req;
   mode_reg_pkg::feature_one_t feat;
   int miscompares = 0, total_checks = 0;

   mode_reg_burst_order #(.COL_W(COL_W)) u_mode_reg_burst_order (
      .SYS_CLK_IN(clk), .RESET_IN(rst), .MR_REQ_IN(req), .MR_RDATA_OUT(rdata),
      .MR_RVALID_OUT(rvalid), .MR_STROBE_OUT(strobe), .AUTO_INIT_BUSY_IN(busy),
      .CALIB_DONE_IN(cdone), .CALIB_RESULT_IN(cres), .CALIB_CMD_IN(ccmd),
      .CALIB_CMD_ACCEPT_OUT(accept), .FACTORY_TRIM_OUT(trim), .BURST_START_IN(bstart),
      .BURST_COL_IN(bcol), .BURST_COL_OUT(bcolo), .BURST_VALID_OUT(bvalid),
      .BURST_ILLEGAL_OUT(billegal), .WRITE_AP_END_IN(apend), .PRECHARGE_START_OUT(pre),
      .FEATURE_OUT(feat));
   mr_ctrl_model u_mr_ctrl_model (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
      .strobe_in(strobe), .req_out(req));

   always #25 clk = ~clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a);
      u_mr_ctrl_model.mr_access(mode_reg_pkg::CMD_READ, a, 8'h00, resp);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_mr_ctrl_model.mr_access(mode_reg_pkg::CMD_WRITE, a, d, resp);
   endtask : wr

   task automatic t_info;
      repeat (3) @(posedge clk);
      chk(16'(feat), 16'h0022, "feature default");
      rd(8'h00);
      chk(16'(resp), 16'h0101, "info while busy");
      busy <= 1'b0;
      repeat (3) @(posedge clk);
      rd(8'h00);
      chk(16'(resp), 16'h0100, "info when done");
      wr(8'h00, 8'hFF);
      chk(16'(feat), 16'h0022, "info write ignored");
      rd(8'h01);
      chk(16'(resp[8]), 16'h0001, "feature read strobe");
      $display("t_info done");
   endtask : t_info

   task automatic t_selftest;
      for (int c = 1; c <= 3; c++) begin
         cdone <= 1'b0;
         cres  <= 2'(c);
         repeat (6) @(posedge clk);
         rd(8'h00);
         chk(16'(resp), 16'({1'b1, 3'h0, prev, 3'h0}), "field held");
         cdone <= 1'b1;
         repeat (6) @(posedge clk);
         rd(8'h00);
         prev = 2'(c);
         chk(16'(resp), 16'({1'b1, 3'h0, prev, 3'h0}), "field result");
         chk(16'(trim), 16'(c < 3), "factory trim");
         @(posedge clk);
         ccmd <= 1'b1;
         #1;
         chk(16'(accept), 16'(c == 3), "calibration accept");
         @(posedge clk);
         ccmd <= 1'b0;
      end
      $display("t_selftest done");
   endtask : t_selftest

   task automatic t_burst(input logic [7:0] f, input logic [COL_W-1:0] c, input int len);
      logic [COL_W-1:0] s, e, m;
      wr(mode_reg_pkg::DEVICE_FEATURE_ONE_ADDR, f);
      s = {c[COL_W-1:1], 1'b0};
      m = COL_W'(len - 1);
      @(posedge clk);
      bstart <= 1'b1;
      bcol   <= c;
      @(posedge clk);
      bstart <= 1'b0;
      #1;
      chk(16'(billegal), 16'(len == 0), "illegal flag");
      for (int i = 0; i < len; i++) begin
         chk(16'(bvalid), 16'h0001, "beat valid");
         if (f[4]) e = s + COL_W'(i);
         else if (f[3]) e = (s & ~m) | ((s ^ COL_W'(i)) & m);
         else e = (s & ~m) | ((s + COL_W'(i)) & m);
         @(posedge clk);
         #1;
         chk(16'(bcolo), 16'(e), "column");
      end
      chk(16'(bvalid), 16'h0000, "burst end");
      $display("t_burst %h done", f);
   endtask : t_burst

   task automatic t_recovery;
      int n;
      for (int k = 1; k <= 6; k++) begin
         wr(mode_reg_pkg::DEVICE_FEATURE_ONE_ADDR,
            u_mr_ctrl_model.feature_byte(50 * (k + 2) - 10, 5'h02));
         @(posedge clk);
         apend <= 1'b1;
         @(posedge clk);
         apend <= 1'b0;
         n = 1;
         while (pre !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
         end
         chk(16'(n), 16'(k + 2), "recovery cycles");
      end
      $display("t_recovery done");
   endtask : t_recovery

   // A second reset in mid-run must bring back the feature defaults that the
   // earlier writes have overwritten.
   task automatic t_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(16'(feat), 16'h0022, "feature after reset");
      $display("t_reset done");
   endtask : t_reset

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test

   initial begin
      #100_000;
      miscompares++;
      finish_test;
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_info;
      t_selftest;
      t_burst(8'h22, 10'h346, 4);
      t_burst(8'h2A, 10'h102, 4);
      t_burst(8'h2B, 10'h00A, 8);
      t_burst(8'h23, 10'h107, 8);
      t_burst(8'h24, 10'h02B, 16);
      t_burst(8'h32, 10'h016, 4);
      t_burst(8'h33, 10'h010, 0);
      t_burst(8'h2C, 10'h010, 0);
      t_burst(8'h20, 10'h010, 0);
      t_recovery;
      t_reset;
      finish_test;
   end
endmodule : mode_reg_burst_order_tb_top

`default_nettype wire
